// File: core/ddot_defs.svh
// Register offsets, reset values and field constants of the dither/offset trim bank
// Function
// - Right secondary dither setting scales constant dither into right secondary modulator low bits.
// - Dither setting is unsigned Q0.11; 1.0 equals 1/32 full-scale modulator input.
// - Code zero adds no dither; each code step adds 2^-11 x 1/32 full scale.
// - Left offset trim register adds manual DC offset to left DAC output.
// - Right offset trim register adds same-encoded DC offset to right DAC output.
// - Applied offset is negated signed register value over four, 0.25 mV per step.
// - Trim codes are two's complement: 0x7f about -31.75 mV, 0x80 +32.0 mV.
`ifndef DDOT_DEFS_SVH
`define DDOT_DEFS_SVH

// Register indices; byte address is four times the index
`define DDOT_IDX_DITHER_A    8'h4b
`define DDOT_IDX_DITHER_B    8'h4c
`define DDOT_IDX_LEFT_TRIM   8'h4e
`define DDOT_IDX_RIGHT_TRIM  8'h4f
`define DDOT_ADDR_DITHER_A   12'h12c
`define DDOT_ADDR_DITHER_B   12'h130
`define DDOT_ADDR_LEFT_TRIM  12'h138
`define DDOT_ADDR_RIGHT_TRIM 12'h13c

// Reset values
`define DDOT_RST_DITHER_A    8'h00
`define DDOT_RST_DITHER_B    8'h00
`define DDOT_RST_LEFT_TRIM   8'h00
`define DDOT_RST_RIGHT_TRIM  8'h00

// Dither field: Q0.11 fraction of 1/32 FS, so one code step is 2^-16 FS
`define DDOT_DITHER_FRAC_BITS 11
`define DDOT_DITHER_FS_SHIFT  5

// AXI responses
`define DDOT_RESP_OKAY   2'b00
`define DDOT_RESP_SLVERR 2'b10

`endif

// File: core/ddot_pkg.sv
// Types shared by the dither/offset trim register bank
package ddot_pkg;

  // Settings delivered to the modulator and output stages
  typedef struct packed {
    logic [15:0]       ditherLevel;  // LSB = 2^-16 of full-scale modulator input
    logic signed [8:0] leftOffset;   // Quarter millivolts, already negated
    logic signed [8:0] rightOffset;  // Quarter millivolts, already negated
  } ddot_trim_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]  ditherA;
    logic [7:0]  ditherB;
    logic [7:0]  leftTrim;
    logic [7:0]  rightTrim;
    logic        awHeld;
    logic [11:0] awAddr;
    logic        wHeld;
    logic [7:0]  wData;
    logic        wLane0;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    ddot_trim_t  trim;
  } ddot_state_t;

endpackage

// File: core/ddot_regs.sv
// AXI4-Lite register bank for right secondary DC dither and left/right offset trim
`timescale 1ns/1ps
`include "ddot_defs.svh"

module ddot_regs
  import ddot_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output ddot_trim_t       trimOut
);

  ddot_state_t st;
  ddot_state_t next_st;

  // Word-aligned decode; low two address bits are ignored
  function automatic logic isMapped(input logic [11:0] addr);
    logic [11:0] a;
    a = {addr[11:2], 2'b00};
    isMapped = (a == `DDOT_ADDR_DITHER_A) || (a == `DDOT_ADDR_DITHER_B) ||
               (a == `DDOT_ADDR_LEFT_TRIM) || (a == `DDOT_ADDR_RIGHT_TRIM);
  endfunction

  // Negate the two's complement code into quarter millivolts; nine bits so 0x80 gives +128
  function automatic logic signed [8:0] trimToQmv(input logic [7:0] code);
    logic signed [8:0] wide;
    wide = {code[7], code};
    trimToQmv = 9'sh000 - wide;
  endfunction

  // Handshake outputs are combinational from state
  assign s_axi_awready = !st.awHeld && !st.bValid;
  assign s_axi_wready  = !st.wHeld && !st.bValid;
  assign s_axi_arready = !st.rValid;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;
  assign trimOut       = st.trim;

  // Next-state logic for bus slave, register file and derived settings
  always_comb begin
    logic [11:0] wa;
    logic [11:0] ra;
    wa = {st.awAddr[11:2], 2'b00};
    ra = {s_axi_araddr[11:2], 2'b00};
    next_st = st;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wHeld  = 1'b1;
      next_st.wData  = s_axi_wdata[7:0];
      next_st.wLane0 = s_axi_wstrb[0];
    end
    // Commit once both halves are held; only byte lane 0 carries data
    if (st.awHeld && st.wHeld) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = isMapped(st.awAddr) ? `DDOT_RESP_OKAY : `DDOT_RESP_SLVERR;
      if (st.wLane0) begin
        unique case (wa)
          `DDOT_ADDR_DITHER_A:   next_st.ditherA = st.wData;
          `DDOT_ADDR_DITHER_B:   next_st.ditherB = st.wData;
          `DDOT_ADDR_LEFT_TRIM:  next_st.leftTrim = st.wData;
          `DDOT_ADDR_RIGHT_TRIM: next_st.rightTrim = st.wData;
          default: ;
        endcase
      end
    end else if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end
    // Read answers one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rValid = 1'b1;
      next_st.rResp  = isMapped(s_axi_araddr) ? `DDOT_RESP_OKAY : `DDOT_RESP_SLVERR;
      unique case (ra)
        `DDOT_ADDR_DITHER_A:   next_st.rData = {24'h000000, st.ditherA};
        `DDOT_ADDR_DITHER_B:   next_st.rData = {24'h000000, st.ditherB};
        `DDOT_ADDR_LEFT_TRIM:  next_st.rData = {24'h000000, st.leftTrim};
        `DDOT_ADDR_RIGHT_TRIM: next_st.rData = {24'h000000, st.rightTrim};
        default:               next_st.rData = 32'h00000000;
      endcase
    end else if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end
    // Settings follow the stored codes one cycle later. The two dither bytes form one
    // Q0.11 code of 1/32 FS, so the code is directly the amount in 2^-16 FS units.
    next_st.trim.ditherLevel = {st.ditherB, st.ditherA};
    next_st.trim.leftOffset  = trimToQmv(st.leftTrim);
    next_st.trim.rightOffset = trimToQmv(st.rightTrim);
  end

  // State register; all trims clear to zero so no dither and no offset at power-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st           <= '0;
      st.ditherA   <= `DDOT_RST_DITHER_A;
      st.ditherB   <= `DDOT_RST_DITHER_B;
      st.leftTrim  <= `DDOT_RST_LEFT_TRIM;
      st.rightTrim <= `DDOT_RST_RIGHT_TRIM;
    end else begin
      st <= next_st;
    end
  end

  // Helper: a write commit with lane 0 enabled, to any address, mapped or not
  logic commitW;
  assign commitW = st.awHeld && st.wHeld && st.wLane0;

  // Delivered dither follows the stored code one cycle later
  a_dither_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (st.ditherA == 8'h00 && st.ditherB == 8'h00) |=> trimOut.ditherLevel == 16'h0000)
    else $error("Zero dither code did not give zero dither");

  a_dither_unit: assert property (@(posedge clk) disable iff (!reset_n)
    (st.ditherA == 8'h01 && st.ditherB == 8'h00) |=> trimOut.ditherLevel == 16'h0001)
    else $error("One dither code step did not give one dither LSB");

  a_dither_scale: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 trimOut.ditherLevel == {$past(st.ditherB), $past(st.ditherA)})
    else $error("Dither level does not track the dither code");

  a_dither_step: assert property (@(posedge clk) disable iff (!reset_n)
    $stable({st.ditherB, st.ditherA}) ##1 $changed(trimOut.ditherLevel) |-> 1'b0)
    else $error("Dither level moved without a code change");

  // Offsets are the negated signed code, in quarter millivolts
  a_left_offset: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 trimOut.leftOffset == -$signed({$past(st.leftTrim[7]), $past(st.leftTrim)}))
    else $error("Left offset is not the negated trim code");

  a_right_offset: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 trimOut.rightOffset == -$signed({$past(st.rightTrim[7]), $past(st.rightTrim)}))
    else $error("Right offset is not the negated trim code");

  a_offset_max: assert property (@(posedge clk) disable iff (!reset_n)
    st.leftTrim == 8'h80 |=> trimOut.leftOffset == 9'sd128)
    else $error("Code 0x80 did not give the most positive offset");

  a_offset_min: assert property (@(posedge clk) disable iff (!reset_n)
    st.rightTrim == 8'h7f |=> trimOut.rightOffset == -9'sd127)
    else $error("Code 0x7f did not give the most negative offset");

  a_offset_step: assert property (@(posedge clk) disable iff (!reset_n)
    st.leftTrim == 8'hff |=> trimOut.leftOffset == 9'sh001)
    else $error("Code 0xff did not give one quarter millivolt");

  // Stored codes move only on a committed write with lane 0 enabled
  a_trim_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !commitW |=> $stable({st.ditherA, st.ditherB, st.leftTrim, st.rightTrim}))
    else $error("Trim register changed without a write");

  a_lane_off: assert property (@(posedge clk) disable iff (!reset_n)
    st.awHeld && st.wHeld && !st.wLane0
      |=> st.bValid && $stable({st.ditherA, st.ditherB, st.leftTrim, st.rightTrim}))
    else $error("Write with lane 0 off changed a register");

  a_write_store: assert property (@(posedge clk) disable iff (!reset_n)
    commitW && {st.awAddr[11:2], 2'b00} == `DDOT_ADDR_LEFT_TRIM
      |=> st.leftTrim == $past(st.wData) && st.bValid)
    else $error("Left trim write not stored");

  a_right_store: assert property (@(posedge clk) disable iff (!reset_n)
    commitW && {st.awAddr[11:2], 2'h0} == `DDOT_ADDR_RIGHT_TRIM
      |=> st.rightTrim == $past(st.wData) && st.bValid)
    else $error("Right trim write not stored");

  a_dither_low: assert property (@(posedge clk) disable iff (!reset_n)
    commitW && {st.awAddr[11:2], 2'h0} == `DDOT_ADDR_DITHER_A
      |=> st.ditherA == $past(st.wData) && st.bValid)
    else $error("Low dither byte write not stored");

  a_dither_high: assert property (@(posedge clk) disable iff (!reset_n)
    commitW && {st.awAddr[11:2], 2'h0} == `DDOT_ADDR_DITHER_B
      |=> st.ditherB == $past(st.wData) && st.bValid)
    else $error("High dither byte write not stored");

  a_unmapped_write: assert property (@(posedge clk) disable iff (!reset_n)
    st.awHeld && st.wHeld && !isMapped(st.awAddr)
      |=> s_axi_bresp == `DDOT_RESP_SLVERR && $stable({st.leftTrim, st.rightTrim}))
    else $error("Unmapped write was not refused");

  // Reads return the last stored code; unmapped reads give zero
  a_read_back: assert property (@(posedge clk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready && {s_axi_araddr[11:2], 2'b00} == `DDOT_ADDR_RIGHT_TRIM
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(st.rightTrim)})
    else $error("Read did not return the stored right trim");

  a_left_read: assert property (@(posedge clk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready && {s_axi_araddr[11:2], 2'h0} == `DDOT_ADDR_LEFT_TRIM
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(st.leftTrim)})
    else $error("Read did not return the stored left trim");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready && !isMapped(s_axi_araddr)
      |=> s_axi_rresp == `DDOT_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("Unmapped read was not refused with zero data");

  // Answers stand until taken, so a slow master never loses one
  a_bvalid_stand: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("Write response dropped before it was taken");

  a_rvalid_stand: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("Read data dropped before it was taken");

  // No disable here: the first edge after release must already show cleared settings
  a_reset_clear: assert property (@(posedge clk)
    $rose(reset_n) |-> trimOut == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("Settings not cleared when reset ends");

endmodule

// File: dv/test_ddot_regs.sv
// Self-checking bench for the dither and offset trim register bank
`timescale 1ns/1ps
`include "ddot_defs.svh"

module test_ddot_regs
  import ddot_pkg::*;
;
  logic        clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rd;
  ddot_trim_t  trimOut;
  logic [7:0]  m [5];
  int          fails = 0, comparisons = 0, cycles = 0;
  // Row: address, data, strobe, model slot, expected response, expected read-back
  // Fields: [57:46] address, [45:38] data, [37] strobe, [36:34] slot, [33:32] resp, [31:0] read
  logic [57:0] rows [8] = '{
    {`DDOT_ADDR_DITHER_A, 8'h01, 1'h1, 3'h0, `DDOT_RESP_OKAY, 32'h01},
    {`DDOT_ADDR_DITHER_B, 8'h80, 1'h1, 3'h1, `DDOT_RESP_OKAY, 32'h80},
    {`DDOT_ADDR_LEFT_TRIM, 8'h80, 1'h1, 3'h2, `DDOT_RESP_OKAY, 32'h80},
    {`DDOT_ADDR_RIGHT_TRIM, 8'h7f, 1'h1, 3'h3, `DDOT_RESP_OKAY, 32'h7f},
    {`DDOT_ADDR_RIGHT_TRIM, 8'h55, 1'h0, 3'h3, `DDOT_RESP_OKAY, 32'h7f},
    {12'h140, 8'h55, 1'h1, 3'h4, `DDOT_RESP_SLVERR, 32'h00},
    {`DDOT_ADDR_LEFT_TRIM, 8'hff, 1'h1, 3'h2, `DDOT_RESP_OKAY, 32'hff},
    {`DDOT_ADDR_DITHER_A, 8'h00, 1'h1, 3'h0, `DDOT_RESP_OKAY, 32'h00}};

  ddot_regs dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trimOut(trimOut));

  always #4 clk = ~clk;

  // Hang guard, generous against the fewer than a hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write: both halves offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic s);
    logic aw, w, awT, wT, bv;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= {3'h0, s};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w) begin
      @(negedge clk);
      awT = aw && awready;
      wT = w && wready;
      @(posedge clk);
      if (awT) begin
        aw = 0;
        awvalid <= 0;
      end
      if (wT) begin
        w = 0;
        wvalid <= 0;
      end
    end
    do begin
      @(negedge clk);
      bv = bvalid;
      resp = bresp;
      @(posedge clk);
    end while (!bv);
    bready <= 0;
  endtask

  // Read: address held until taken, then data awaited with rready up
  task automatic rdw(input logic [11:0] a);
    logic ar, rv;
    ar = 1;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge clk);
      ar = !arready;
      rv = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      if (!ar) arvalid <= 0;
    end while (!rv);
    rready <= 0;
  endtask

  // Expected settings: dither {B,A}; offsets are the negated signed codes
  function automatic ddot_trim_t exp_trim();
    exp_trim.ditherLevel = {m[1], m[0]};
    exp_trim.leftOffset = 9'h000 - {m[2][7], m[2]};
    exp_trim.rightOffset = 9'h000 - {m[3][7], m[3]};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (6) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    chk(trimOut, 34'h0);
    foreach (rows[i]) begin
      wr(rows[i][57:46], rows[i][45:38], rows[i][37]);
      if (rows[i][37] && rows[i][36:34] < 3'h4) m[rows[i][36:34]] = rows[i][45:38];
      chk(resp, rows[i][33:32]);
      repeat (2) @(posedge clk);
      chk(trimOut, exp_trim());
      rdw(rows[i][57:46]);
      chk(rd, rows[i][31:0]);
      chk(resp, rows[i][33:32]);
    end
    // Second reset in mid-run must clear every trim register
    reset_n <= 0;
    repeat (6) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    chk(trimOut, 34'h0);
    rdw(`DDOT_ADDR_LEFT_TRIM);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule
